// ===== verilog/gic_pkg.sv
// Notes on behaviour
// [RL1] Edge mode: each period is gate length samples, then spacing samples of gap.
// [RL2] Edge mode stores gate samples until the total count is reached, then stops.
// [RL3] Level mode stores only the samples taken while the gate input is high.
// [RL4] With the IF power source the gate is high while power exceeds threshold.
// [RL5] A programmable number of samples before the trigger is kept in the capture.
// [RL6] Pretrigger samples are kept for every trigger source except free run.
// [RL7] Gating off means ungated capture; gating on applies edge or level gating.
// [RL8] Software picks I/Q mode and external or IF power trigger before enabling.
// [RL9] Period spacing in samples, at least 1, resets to 1.
// [RL10] Gate length in samples, at least 1, resets to 100.
// [RL11] Period count is clamped to 1..1023 and resets to 1.
// [RL12] Gate mode is level or edge; edge after reset.
// [RL13] Level mode with the IF power trigger ignores the trigger holdoff.
// [RL14] Gating only applies while acquisition bandwidth is 28 MHz or less.
// [RL15] Lengths count sample cycles; edge mode ends after the last period.
// [RL16] Triggers are ignored during a sequence; re-arm after it ends or aborts.
`default_nettype none
package gic_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_SPACING = 8'h04;
    localparam logic [7:0] OFS_LENGTH  = 8'h08;
    localparam logic [7:0] OFS_PERIODS = 8'h0C;
    localparam logic [7:0] OFS_PRETRIG = 8'h10;
    localparam logic [7:0] OFS_TOTAL   = 8'h14;
    localparam logic [7:0] OFS_THRESH  = 8'h18;
    localparam logic [7:0] OFS_HOLDOFF = 8'h1C;
    localparam logic [7:0] OFS_BW      = 8'h20;
    localparam logic [7:0] OFS_STATUS  = 8'h24;
    localparam logic [7:0] OFS_STORED  = 8'h28;
    localparam int CTRL_EN    = 0;
    localparam int CTRL_LEVEL = 1;
    localparam int CTRL_SRC   = 2;
    localparam int CTRL_START = 4;
    // ----------------------------------------
    // Reset values and limits
    // ----------------------------------------
    localparam logic [31:0] RST_SPACING = 32'h0000_0001;
    localparam logic [31:0] RST_LENGTH  = 32'h0000_0064;
    localparam logic [9:0]  RST_PERIODS = 10'h001;
    localparam logic [9:0]  PERIODS_MAX = 10'h3FF;
    localparam logic [31:0] RST_TOTAL   = 32'h0000_0400;
    localparam logic [7:0]  BW_GATE_MAX = 8'h1C;
    localparam int          DLY_DEPTH   = 16;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_GATE = 4'h2,
        ST_GAP  = 4'h4,
        ST_LVL  = 4'h8
    } gic_state_t;
    typedef enum logic [1:0] {
        SRC_FREE = 2'h0,
        SRC_EXT  = 2'h1,
        SRC_IFP  = 2'h2
    } gic_src_t;
    typedef struct packed {
        logic [15:0] i;
        logic [15:0] q;
    } gic_sample_t;
    typedef struct packed {
        logic        valid;
        gic_sample_t data;
    } gic_stream_t;
endpackage
`default_nettype wire

// ===== verilog/gic_capture_ctrl.sv
// Design decisions made here: register access over AHB-Lite and the placing of the registers.
`default_nettype none
module gic_capture_ctrl (
    input  wire logic                clk_sys,
    input  wire logic                resetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata,
    input  wire gic_pkg::gic_stream_t in_s,
    input  wire logic                ext_trig,
    input  wire logic                ext_gate,
    input  wire logic [15:0]         if_power,
    output gic_pkg::gic_stream_t     out_s,
    output logic                     busy
);
    localparam int DLY = gic_pkg::DLY_DEPTH;

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    logic        wr_pend_r;
    logic [7:0]  wr_addr_r;
    logic [31:0] hrdata_r;
    logic [31:0] rdata_nxt;
    wire         bus_take = hsel && hready && htrans[1];
    wire         rd_take  = bus_take && !hwrite;
    wire         wr_take  = bus_take && hwrite;

    function automatic logic wr_hit(input logic [7:0] ofs);
        wr_hit = wr_pend_r && (wr_addr_r == ofs);
    endfunction

    function automatic logic [31:0] min1(input logic [31:0] v);
        min1 = (v == 32'h0) ? 32'h1 : v;
    endfunction

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= wr_take;
            wr_addr_r <= haddr[7:0];
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    logic        en_r;
    logic        lvl_r;
    logic [1:0]  src_r;
    logic [31:0] spacing_r;
    logic [31:0] length_r;
    logic [9:0]  periods_r;
    logic [3:0]  pretrig_r;
    logic [31:0] total_r;
    logic [15:0] thr_r;
    logic [15:0] holdoff_r;
    logic [7:0]  bw_r;
    wire         start_wr = wr_hit(gic_pkg::OFS_CTRL)
                            && hwdata[gic_pkg::CTRL_START];
    wire  [9:0]  per_wr   = (hwdata[31:10] != 22'h0)
                            ? gic_pkg::PERIODS_MAX
                            : ((hwdata[9:0] == 10'h0) ? 10'h1 : hwdata[9:0]);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            en_r      <= 1'b0;
            lvl_r     <= 1'b0; // RL12
            src_r     <= 2'h0;
            spacing_r <= gic_pkg::RST_SPACING;
            length_r  <= gic_pkg::RST_LENGTH;
            periods_r <= gic_pkg::RST_PERIODS;
            pretrig_r <= 4'h0;
            total_r   <= gic_pkg::RST_TOTAL;
            thr_r     <= 16'h0000;
            holdoff_r <= 16'h0000;
            bw_r      <= 8'h00;
        end else begin
            if (wr_hit(gic_pkg::OFS_CTRL)) begin
                en_r  <= hwdata[gic_pkg::CTRL_EN];
                lvl_r <= hwdata[gic_pkg::CTRL_LEVEL]; // RL12
                src_r <= hwdata[gic_pkg::CTRL_SRC +: 2];
            end
            if (wr_hit(gic_pkg::OFS_SPACING)) begin
                spacing_r <= min1(hwdata); // RL9
            end
            if (wr_hit(gic_pkg::OFS_LENGTH)) begin
                length_r <= min1(hwdata); // RL10
            end
            if (wr_hit(gic_pkg::OFS_PERIODS)) begin
                periods_r <= per_wr; // RL11
            end
            if (wr_hit(gic_pkg::OFS_PRETRIG)) begin
                pretrig_r <= hwdata[3:0]; // RL5
            end
            if (wr_hit(gic_pkg::OFS_TOTAL)) begin
                total_r <= min1(hwdata);
            end
            if (wr_hit(gic_pkg::OFS_THRESH)) begin
                thr_r <= hwdata[15:0];
            end
            if (wr_hit(gic_pkg::OFS_HOLDOFF)) begin
                holdoff_r <= hwdata[15:0];
            end
            if (wr_hit(gic_pkg::OFS_BW)) begin
                bw_r <= hwdata[7:0];
            end
        end
    end

    // ----------------------------------------
    // Trigger and gate sources
    // ----------------------------------------
    gic_pkg::gic_state_t state_r;
    gic_pkg::gic_state_t state_nxt;
    logic        armed_r;
    logic        done_r;
    logic        seq_gated_r;
    logic        ext_d_r;
    logic        ifp_d_r;
    logic [15:0] hold_cnt_r;
    logic [31:0] len_cnt_r;
    logic [31:0] gap_cnt_r;
    logic [9:0]  per_cnt_r;
    logic [31:0] stored_r;

    wire gating_ok  = en_r && (bw_r <= gic_pkg::BW_GATE_MAX); // RL7 RL14
    wire ifp_high   = if_power > thr_r; // RL4
    wire ext_edge   = ext_trig && !ext_d_r;
    wire ifp_edge   = ifp_high && !ifp_d_r;
    wire src_free   = src_r == gic_pkg::SRC_FREE;
    wire src_ifp    = src_r == gic_pkg::SRC_IFP;
    wire gate_lvl   = src_ifp ? ifp_high : ext_gate; // RL4
    wire use_lvl    = gating_ok && lvl_r;
    // Holdoff belongs to the IF power trigger only; other sources pass
    wire hold_block = src_ifp && (hold_cnt_r != 16'h0) && !use_lvl; // RL13
    wire trig_evt   = src_free || (src_r == gic_pkg::SRC_EXT && ext_edge)
                      || (src_ifp && ifp_edge);
    // Only an armed idle controller looks at triggers
    wire trig_take  = in_s.valid && armed_r && (state_r == gic_pkg::ST_IDLE)
                      && !hold_block && trig_evt; // RL16
    wire pre_mark   = trig_take && !src_free; // RL6

    // ----------------------------------------
    // Sequence control
    // ----------------------------------------
    wire [31:0] eff_len  = gating_ok ? length_r : total_r; // RL7
    wire [9:0]  eff_per  = gating_ok ? periods_r : 10'h1;
    wire st_gate    = state_r == gic_pkg::ST_GATE;
    wire st_gap     = state_r == gic_pkg::ST_GAP;
    wire st_lvl     = state_r == gic_pkg::ST_LVL;
    wire keep_live  = in_s.valid && (st_gate || (st_lvl && gate_lvl)); // RL3
    wire last_total = keep_live && (stored_r + 32'h1 == total_r); // RL2
    wire last_len   = st_gate && in_s.valid
                      && (len_cnt_r + 32'h1 == eff_len); // RL1 RL15
    wire last_per   = per_cnt_r + 10'h1 == eff_per; // RL15
    wire last_gap   = st_gap && in_s.valid
                      && (gap_cnt_r + 32'h1 == spacing_r); // RL1
    wire abort      = (state_r != gic_pkg::ST_IDLE) && seq_gated_r
                      && !gating_ok; // RL16
    wire seq_end    = last_total || (last_len && last_per) || abort;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            gic_pkg::ST_IDLE: begin
                if (trig_take) begin
                    state_nxt = use_lvl ? gic_pkg::ST_LVL : gic_pkg::ST_GATE;
                end
            end
            gic_pkg::ST_GATE: begin
                if (seq_end) begin
                    state_nxt = gic_pkg::ST_IDLE; // RL2 RL15
                end else if (last_len) begin
                    state_nxt = gic_pkg::ST_GAP; // RL1
                end
            end
            gic_pkg::ST_GAP: begin
                if (seq_end) begin
                    state_nxt = gic_pkg::ST_IDLE;
                end else if (last_gap) begin
                    state_nxt = gic_pkg::ST_GATE; // RL1
                end
            end
            gic_pkg::ST_LVL: begin
                if (seq_end) begin
                    state_nxt = gic_pkg::ST_IDLE;
                end
            end
            default: state_nxt = gic_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_r     <= gic_pkg::ST_IDLE;
            seq_gated_r <= 1'b0;
            ext_d_r     <= 1'b0;
            ifp_d_r     <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            seq_gated_r <= trig_take ? gating_ok : seq_gated_r;
            ext_d_r     <= ext_trig;
            ifp_d_r     <= ifp_high;
        end
    end

    // Set of done wins over the clear by a start write
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            armed_r <= 1'b0;
            done_r  <= 1'b0;
        end else begin
            armed_r <= !trig_take && (armed_r || (start_wr && !busy));
            done_r  <= (seq_end && busy) || (done_r && !start_wr);
        end
    end

    // IF power holdoff blocks new triggers unless level gating is in use
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            hold_cnt_r <= 16'h0000;
        end else if (seq_end && busy && src_ifp) begin
            hold_cnt_r <= holdoff_r;
        end else if (in_s.valid && hold_cnt_r != 16'h0) begin
            hold_cnt_r <= hold_cnt_r - 16'h1;
        end
    end

    // Counters run in sample cycles
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            len_cnt_r <= 32'h0;
            gap_cnt_r <= 32'h0;
            per_cnt_r <= 10'h0;
            stored_r  <= 32'h0;
        end else begin
            if (trig_take || last_gap) begin
                len_cnt_r <= 32'h0;
            end else if (st_gate && in_s.valid) begin
                len_cnt_r <= len_cnt_r + 32'h1; // RL15
            end
            if (last_len) begin
                gap_cnt_r <= 32'h0;
            end else if (st_gap && in_s.valid) begin
                gap_cnt_r <= gap_cnt_r + 32'h1; // RL15
            end
            if (trig_take) begin
                per_cnt_r <= 10'h0;
            end else if (last_gap) begin
                per_cnt_r <= per_cnt_r + 10'h1;
            end
            if (trig_take) begin
                stored_r <= 32'h0;
            end else if (keep_live) begin
                stored_r <= stored_r + 32'h1; // RL2
            end
        end
    end

    assign busy = state_r != gic_pkg::ST_IDLE;

    always_comb begin
        case (haddr[7:0])
            gic_pkg::OFS_CTRL:    rdata_nxt = {27'h0, 1'b0, src_r, lvl_r, en_r};
            gic_pkg::OFS_SPACING: rdata_nxt = spacing_r;
            gic_pkg::OFS_LENGTH:  rdata_nxt = length_r;
            gic_pkg::OFS_PERIODS: rdata_nxt = {22'h0, periods_r};
            gic_pkg::OFS_PRETRIG: rdata_nxt = {28'h0, pretrig_r};
            gic_pkg::OFS_TOTAL:   rdata_nxt = total_r;
            gic_pkg::OFS_THRESH:  rdata_nxt = {16'h0, thr_r};
            gic_pkg::OFS_HOLDOFF: rdata_nxt = {16'h0, holdoff_r};
            gic_pkg::OFS_BW:      rdata_nxt = {24'h0, bw_r};
            gic_pkg::OFS_STATUS:  rdata_nxt = {29'h0, armed_r, done_r, busy};
            gic_pkg::OFS_STORED:  rdata_nxt = stored_r;
            default:              rdata_nxt = 32'h0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            hrdata_r <= 32'h0;
        end else if (rd_take) begin
            hrdata_r <= rdata_nxt;
        end
    end

    // ----------------------------------------
    // Pretrigger delay line
    // ----------------------------------------
    // Fixed depth trades latency for keeping up to DLY-1 early samples
    gic_pkg::gic_sample_t dl_r [DLY];
    logic                 kp_r [DLY];
    genvar g;
    generate
        for (g = 0; g < DLY; g++) begin : g_dly
            if (g == 0) begin : g_head
                always_ff @(posedge clk_sys or negedge resetn) begin
                    if (!resetn) begin
                        dl_r[0] <= '0;
                        kp_r[0] <= 1'b0;
                    end else if (in_s.valid) begin
                        dl_r[0] <= in_s.data;
                        kp_r[0] <= keep_live;
                    end
                end
            end else begin : g_tail
                wire mark = pre_mark && (4'(g) <= pretrig_r); // RL5 RL6
                always_ff @(posedge clk_sys or negedge resetn) begin
                    if (!resetn) begin
                        dl_r[g] <= '0;
                        kp_r[g] <= 1'b0;
                    end else if (in_s.valid) begin
                        dl_r[g] <= dl_r[g-1];
                        kp_r[g] <= kp_r[g-1] | mark;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            out_s <= '0;
        end else begin
            out_s.valid <= in_s.valid && kp_r[DLY-1];
            out_s.data  <= dl_r[DLY-1];
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence s_gate_end;
        st_gate && last_len && !seq_end;
    endsequence
    sequence s_gap_end;
        st_gap && last_gap && !seq_end;
    endsequence

    property p_gate_to_gap;
        s_gate_end |=> st_gap && gap_cnt_r == 32'h0;
    endproperty
    a_gate_to_gap: assert property (p_gate_to_gap) else $error("no gap"); // RL1
    property p_gap_to_gate;
        s_gap_end |=> st_gate && len_cnt_r == 32'h0;
    endproperty
    a_gap_to_gate: assert property (p_gap_to_gate) else $error("no gate"); // RL1
    property p_total_stop;
        last_total |=> !busy && stored_r == $past(total_r);
    endproperty
    a_total_stop: assert property (p_total_stop) else $error("total"); // RL2
    property p_level_drop;
        st_lvl && in_s.valid && !gate_lvl |=> stored_r == $past(stored_r);
    endproperty
    a_level_drop: assert property (p_level_drop) else $error("lvl"); // RL3
    property p_ifp_gate;
        st_lvl && src_ifp && in_s.valid && !last_total && if_power > thr_r
        |=> stored_r == $past(stored_r) + 32'h1;
    endproperty
    a_ifp_gate: assert property (p_ifp_gate) else $error("ifp"); // RL4
    property p_pre_keep;
        pre_mark && pretrig_r != 4'h0 |=> kp_r[1];
    endproperty
    a_pre_keep: assert property (p_pre_keep) else $error("pretrig"); // RL5
    property p_free_none;
        trig_take && src_free |=> kp_r[1] == $past(kp_r[0]);
    endproperty
    a_free_none: assert property (p_free_none) else $error("free"); // RL6
    property p_ungated;
        trig_take && !gating_ok |=> st_gate;
    endproperty
    a_ungated: assert property (p_ungated) else $error("ungated"); // RL7 RL14
    property p_level_mode;
        trig_take && use_lvl |=> st_lvl;
    endproperty
    a_level_mode: assert property (p_level_mode) else $error("mode"); // RL12
    property p_nonzero;
        spacing_r != 32'h0 && length_r != 32'h0 && periods_r != 10'h0;
    endproperty
    a_nonzero: assert property (p_nonzero) else $error("range"); // RL9 RL10 RL11
    property p_no_holdoff;
        use_lvl && armed_r && !busy && in_s.valid && trig_evt |=> st_lvl;
    endproperty
    a_no_holdoff: assert property (p_no_holdoff) else $error("hold"); // RL13
    property p_last_period;
        st_gate && last_len && last_per |=> !busy && done_r;
    endproperty
    a_last_period: assert property (p_last_period) else $error("end"); // RL15
    property p_busy_ignore;
        st_gap && !seq_end && !last_gap |=> st_gap
        && per_cnt_r == $past(per_cnt_r);
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("retrig"); // RL16
endmodule
`default_nettype wire

// ===== tb/gic_src_model.sv
`default_nettype none
module gic_src_model (
    input  wire logic            clk_sys,
    input  wire logic            resetn,
    input  wire logic            fire,
    input  wire logic            slow,
    output gic_pkg::gic_stream_t in_s,
    output logic                 ext_trig,
    output logic                 ext_gate,
    output logic [15:0]          if_power,
    output logic [15:0]          trig_i
);
    timeunit 1ns;
    timeprecision 100ps;
    logic        ph;
    logic        pend;
    logic [15:0] cnt;
    // ------------
    // Ramp source
    // ------------
    // Gate and power follow the sample on the wire
    assign ext_gate = in_s.data.i[1];
    assign if_power = in_s.data.i[2] ? 16'h0100 : 16'h0000;
    // Trigger waits for a valid sample; idle data inverted, never stale
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ph       <= 1'b0;
            pend     <= 1'b0;
            cnt      <= 16'h0000;
            in_s     <= '0;
            ext_trig <= 1'b0;
            trig_i   <= 16'h0000;
        end else begin
            ph <= ~ph;
            if (fire) begin
                pend <= 1'b1;
            end
            if (!slow || ph) begin
                in_s     <= {1'b1, cnt, ~cnt};
                cnt      <= cnt + 16'h0001;
                ext_trig <= pend;
                if (pend) begin
                    trig_i <= cnt;
                    pend   <= 1'b0;
                end
            end else begin
                in_s.valid <= 1'b0;
                in_s.data  <= ~in_s.data;
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic                 clk_sys, resetn, hsel, hwrite, fire, slow;
    logic                 hreadyout, hresp, ext_trig, ext_gate, busy;
    logic [1:0]           htrans;
    logic [31:0]          haddr, hwdata, hrdata, x;
    logic [15:0]          if_power, trig_i, tv;
    logic [15:0]          q[$];
    gic_pkg::gic_stream_t in_s, out_s;
    int                   bad_count, compares;
    // ------------
    // Harness
    // ------------
    gic_capture_ctrl DUT (
        .clk_sys, .resetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
        .hrdata, .in_s, .ext_trig, .ext_gate, .if_power, .out_s, .busy
    );
    gic_src_model src (
        .clk_sys, .resetn, .fire, .slow, .in_s, .ext_trig, .ext_gate,
        .if_power, .trig_i
    );
    initial clk_sys = 1'b0;
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (out_s.valid === 1'b1) begin
            q.push_back(out_s.data.i);
            if (out_s.data.q !== ~out_s.data.i) begin
                bad_count++;
                $display("[ERR] %0t q lane not carried", $time);
            end
        end
    end
    // ------------
    // Helpers
    // ------------
    task automatic stop_test();
        if (bad_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] d);
        @(posedge clk_sys);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask
    task automatic pulse();
        @(posedge clk_sys);
        fire <= 1'b1;
        @(posedge clk_sys);
        fire <= 1'b0;
    endtask
    task automatic cfg(input logic [15:0] l, s, p, t,
                       input logic [7:0] pr, bw);
        bus(1'b1, gic_pkg::OFS_LENGTH, {16'h0000, l}, x);
        bus(1'b1, gic_pkg::OFS_SPACING, {16'h0000, s}, x);
        bus(1'b1, gic_pkg::OFS_PERIODS, {16'h0000, p}, x);
        bus(1'b1, gic_pkg::OFS_TOTAL, {16'h0000, t}, x);
        bus(1'b1, gic_pkg::OFS_PRETRIG, {24'h000000, pr}, x);
        bus(1'b1, gic_pkg::OFS_BW, {24'h000000, bw}, x);
    endtask
    // Bounded wait on done; outputs trail the sequence by the delay line
    task automatic arm(input logic [31:0] ctl, input logic tw);
        logic [31:0] st;
        int          n;
        q.delete();
        bus(1'b1, gic_pkg::OFS_CTRL, ctl | 32'h0000_0010, x);
        pulse();
        repeat (3) @(posedge clk_sys);
        tv = trig_i;
        if (tw) begin
            pulse();
        end
        st = 32'h0000_0000;
        n  = 0;
        while (st[1] !== 1'b1 && n < 500) begin
            bus(1'b0, gic_pkg::OFS_STATUS, 32'h0000_0000, st);
            n++;
        end
        chk(st, 32'h0000_0002);
        chk(busy, 1'b0);
        repeat (40) @(posedge clk_sys);
    endtask
    function automatic logic [15:0] nxt(input logic [15:0] v, input int b);
        logic [15:0] r;
        r = v + 16'h0001;
        while (r[b] !== 1'b1) r = r + 16'h0001;
        return r;
    endfunction
    task automatic expq(input int n, input int off[5]);
        chk(q.size(), n);
        for (int i = 0; i < n; i++) begin
            chk(q[i], 16'(tv + off[i]));
        end
    endtask
    // ------------
    // Scenarios
    // ------------
    task automatic t_regs();
        logic [7:0]  a[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h40};
        logic [31:0] e[6] = '{32'h0000_0000, 32'h0000_0001, 32'h0000_0064,
                              32'h0000_0001, 32'h0000_0000, 32'h0000_0000};
        logic [31:0] d;
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, a[i], 32'h0000_0000, d);
            chk(d, e[i]);
        end
        chk(hresp, 1'b0);
        bus(1'b1, gic_pkg::OFS_PERIODS, 32'h0000_0800, x);
        bus(1'b0, gic_pkg::OFS_PERIODS, 32'h0000_0000, d);
        chk(d, 32'h0000_03FF);
        bus(1'b1, gic_pkg::OFS_SPACING, 32'h0000_0000, x);
        bus(1'b0, gic_pkg::OFS_SPACING, 32'h0000_0000, d);
        chk(d, 32'h0000_0001);
    endtask
    task automatic t_gate(input logic [15:0] l, s, p, t, input logic tw,
                          input int off[5]);
        logic [31:0] d;
        cfg(l, s, p, t, 8'h00, 8'h1C);
        arm(32'h0000_0005, tw);
        expq(4, off);
        bus(1'b0, gic_pkg::OFS_STORED, 32'h0000_0000, d);
        chk(d, 32'h0000_0004);
    endtask
    task automatic t_level(input logic [31:0] ctl, input int b);
        logic [15:0] e;
        cfg(16'h0002, 16'h0001, 16'h0001, 16'h0006, 8'h00, 8'h00);
        bus(1'b1, gic_pkg::OFS_THRESH, 32'h0000_0080, x);
        bus(1'b1, gic_pkg::OFS_HOLDOFF, 32'h0000_FFFF, x);
        arm(ctl, 1'b0);
        e = (b == 1) ? nxt(tv, 1) : q[0];
        chk(q.size(), 6);
        chk(e[b], 1'b1);
        if (b == 2) chk(e[1:0], 2'h1);
        for (int i = 0; i < 6; i++) begin
            chk(q[i], e);
            e = nxt(e, b);
        end
    endtask
    task automatic t_ungated(input logic [31:0] ctl, input logic [7:0] bw,
                             input logic sl);
        cfg(16'h0002, 16'h0001, 16'h0001, 16'h0005, 8'h00, bw);
        slow <= sl;
        arm(ctl, 1'b0);
        expq(5, '{1, 2, 3, 4, 5});
        slow <= 1'b0;
    endtask
    task automatic t_pretrig();
        logic [31:0] d;
        cfg(16'h0002, 16'h0001, 16'h0001, 16'h0002, 8'h03, 8'h00);
        arm(32'h0000_0004, 1'b0);
        expq(5, '{-3, -2, -1, 1, 2});
        bus(1'b0, gic_pkg::OFS_STORED, 32'h0000_0000, d);
        chk(d, 32'h0000_0002);
        arm(32'h0000_0000, 1'b0);
        chk(q.size(), 2);
        chk(q[1], 16'(q[0] + 16'h0001));
    endtask
    // ------------
    // Main sequence and watchdog
    // ------------
    initial begin
        resetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0000_0000;
        fire = 1'b0;
        slow = 1'b0;
        tv = 16'h0000;
        bad_count = 0;
        compares = 0;
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        t_regs();
        t_gate(16'h2, 16'h1, 16'h2, 16'h400, 1'b1, '{1, 2, 4, 5, 0});
        t_gate(16'h3, 16'h2, 16'h5, 16'h4, 1'b0, '{1, 2, 3, 6, 0});
        t_level(32'h0000_0007, 1);
        t_level(32'h0000_000B, 2);
        t_level(32'h0000_000B, 2);
        t_ungated(32'h0000_0004, 8'h00, 1'b1);
        t_ungated(32'h0000_0005, 8'h1D, 1'b0);
        t_pretrig();
        stop_test();
    end
    initial begin
        repeat (30000) @(posedge clk_sys);
        bad_count++;
        stop_test();
    end
endmodule
`default_nettype wire
